// *** logic/wit_axil.sv ***
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module wit_axil
   import wit_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   input  wire logic [17:0] i_awaddr,
   input  wire logic        i_awvalid,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   input  wire logic        i_bready,
   input  wire logic [17:0] i_araddr,
   input  wire logic        i_arvalid,
   input  wire logic        i_rready,
   output var  wit_axs_t    o_st,
   output var  logic        o_wr_valid,
   output var  wit_wreq_t   o_wr,
   input  wire logic        i_wr_ok,
   output var  logic        o_rd_valid,
   output var  logic [17:0] o_rd_addr,
   input  wire wit_rresp_t  i_rd
);
`include "wit_defs.svh"
   wit_axs_t s_r;
   wit_axs_t s_nxt;

   // write fires once both halves are held and the last answer is gone
   assign o_wr_valid = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
   assign o_wr       = '{addr: s_r.awaddr, data: s_r.wdata, strb: s_r.wstrb};
   assign o_rd_valid = i_arvalid & s_r.ardy;
   assign o_rd_addr  = i_araddr;
   assign o_st       = s_r;

   // address and data are taken in either order
   always_comb
   begin
      s_nxt = s_r;
      if (i_awvalid && s_r.awrdy)
      begin
         s_nxt.aw_have = 1'b1;
         s_nxt.awaddr  = i_awaddr;
      end
      if (i_wvalid && s_r.wrdy)
      begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata  = i_wdata;
         s_nxt.wstrb  = i_wstrb;
      end
      if (s_r.bvalid && i_bready)
         s_nxt.bvalid = 1'b0;
      if (o_wr_valid)
      begin
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = i_wr_ok ? `WIT_RESP_OKAY : `WIT_RESP_DECERR;
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
      end
      if (s_r.rvalid && i_rready)
         s_nxt.rvalid = 1'b0;
      if (o_rd_valid)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = i_rd.data;
         s_nxt.rresp  = i_rd.ok ? `WIT_RESP_OKAY : `WIT_RESP_DECERR;
      end
      // readies are kept as flops so the ports come straight from registers
      s_nxt.awrdy = ~s_nxt.aw_have;
      s_nxt.wrdy  = ~s_nxt.w_have;
      s_nxt.ardy  = ~s_nxt.rvalid;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule
`default_nettype wire

// *** logic/wit_defs.svh ***
// constants of the watch and interval timer: offsets, fields, taps, reset values
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH
// register indexes; the byte address is four times the index
`define WIT_IDX_MODE     16'hff6f
`define WIT_IDX_STATUS   16'hff70
`define WIT_IDX_CLEAR    16'hff71
`define WIT_IDX_ENABLE   16'hff72
`define WIT_IDX_BITOP    16'hff73
`define WIT_IDX_COUNT    16'hff74
`define WIT_ADDR_W       18
// reset values
`define WIT_MODE_RESET   8'h00
`define WIT_EN_RESET     2'h0
// status, clear and enable layout
`define WIT_EV_WATCH     0
`define WIT_EV_INTV      1
// single-bit write register: value bit and bit-number field
`define WIT_BITOP_VAL    3
`define WIT_BITOP_POS_HI 2
// high-speed clock divider, 128 = 2^7
`define WIT_DIV_W        7
// prescaler and counter widths and taps
`define WIT_PRE_W        11
`define WIT_CNT_W        5
`define WIT_TAP_COUNT    9
`define WIT_TAP_W5       5
`define WIT_TAP_W4       4
`define WIT_TAP_IBASE    4'h4
// counter values that end a 2^14 or 2^13 watch period
`define WIT_CNT_LAST     5'h1f
`define WIT_CNT_HALF     4'hf
// bus answers
`define WIT_RESP_OKAY    2'h0
`define WIT_RESP_DECERR  2'h3
`endif

// *** logic/wit_pkg.sv ***
// types of the watch and interval timer
package wit_pkg;
   // mode register, bit 7 down to bit 0
   typedef struct packed {
      logic       count_clock_select;
      logic [2:0] interval_select;
      logic [1:0] watch_period_select;
      logic       counter_run;
      logic       operation_enable;
   } wit_mode_t;
   // one register write
   typedef struct packed {
      logic [17:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wit_wreq_t;
   // one register read answer
   typedef struct packed {
      logic [31:0] data;
      logic        ok;
   } wit_rresp_t;
   // bus slave state
   typedef struct packed {
      logic        aw_have;
      logic        awrdy;
      logic [17:0] awaddr;
      logic        w_have;
      logic        wrdy;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ardy;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } wit_axs_t;
   // timer core state
   typedef struct packed {
      wit_mode_t   mode;
      logic [6:0]  div;
      logic [10:0] pre;
      logic [4:0]  cnt;
      logic [1:0]  status;
      logic [1:0]  irq_en;
      logic        watch_p;
      logic        intv_p;
      logic        irq;
   } wit_core_t;
   // synchroniser state
   typedef struct packed {
      logic [2:0] sh;
   } wit_sync_t;
endpackage

// *** logic/wit_sync.sv ***
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module wit_sync
   import wit_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_srst,
   input  wire logic i_pin,
   output var  logic o_rise
);
   wit_sync_t s_r;
   wit_sync_t s_nxt;

   // sh[0] is read only by sh[1]; the edge looks at sh[2:1]
   always_comb
   begin
      s_nxt.sh = {s_r.sh[1:0], i_pin};
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign o_rise = s_r.sh[1] & ~s_r.sh[2];
endmodule
`default_nettype wire

// *** logic/wit_top.sv ***
// watch and interval timer: prescaler, 5-bit counter, mode register, axi4-lite slave
//
// How it works
// - the watch clock is the system clock divided by 128 when count_clock_select is 0, else the subsystem clock.
// - interval_select codes 0 to 7 pick prescaler periods of 2^4 to 2^11 watch-clock cycles for interval_irq.
// - watch_period_select codes 00, 01, 10, 11 give watch_irq periods of 2^14, 2^13, 2^5 and 2^4 cycles.
// - counter_run at 1 lets the 5-bit counter count; at 0 it stops and clears it.
// - operation_enable at 0 stops the block and clears prescaler and counter; at 1 the block runs.
// - watch counting and watch_irq happen only while operation_enable and counter_run are both 1.
// - clearing only counter_run clears the 5-bit counter while the 11-bit prescaler keeps counting.
// - the first watch_irq after a start may be early by up to 2^9 cycles, later ones come at the exact period.
// - interval_irq repeats at its period whenever operation_enable is 1, whatever counter_run is.
// - reset clears the whole mode register to zero.
// - the mode register is read and written as a byte, and single bits can be written alone.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wit_top
   import wit_pkg::*;
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_SRST,
   input  wire logic        I_SUB_CLK,
   input  wire logic [17:0] I_AXI_AWADDR,
   input  wire logic        I_AXI_AWVALID,
   output var  logic        O_AXI_AWREADY,
   input  wire logic [31:0] I_AXI_WDATA,
   input  wire logic [3:0]  I_AXI_WSTRB,
   input  wire logic        I_AXI_WVALID,
   output var  logic        O_AXI_WREADY,
   output var  logic [1:0]  O_AXI_BRESP,
   output var  logic        O_AXI_BVALID,
   input  wire logic        I_AXI_BREADY,
   input  wire logic [17:0] I_AXI_ARADDR,
   input  wire logic        I_AXI_ARVALID,
   output var  logic        O_AXI_ARREADY,
   output var  logic [31:0] O_AXI_RDATA,
   output var  logic [1:0]  O_AXI_RRESP,
   output var  logic        O_AXI_RVALID,
   input  wire logic        I_AXI_RREADY,
   output var  logic        O_WATCH_IRQ,
   output var  logic        O_INTERVAL_IRQ,
   output var  logic        O_IRQ
);
`include "wit_defs.svh"

   wit_core_t   c_r;
   wit_core_t   c_nxt;
   wit_axs_t    axs;
   logic        wr_valid;
   wit_wreq_t   wr;
   logic        wr_ok;
   logic        rd_valid;
   logic [17:0] rd_addr;
   wit_rresp_t  rd;
   logic        sub_rise;
   logic        tick;
   logic [11:0] hit;
   logic [15:0] wr_idx;
   logic [15:0] rd_idx;
   logic        run_watch;
   logic        watch_ev;
   logic [1:0]  clr;
   logic [2:0]  bit_pos;

   // subsystem clock pin, sampled on the system clock
   wit_sync u_sync (
      .i_clock (I_CLOCK),
      .i_srst  (I_SRST),
      .i_pin   (I_SUB_CLK),
      .o_rise  (sub_rise)
   );

   // register bus
   wit_axil u_axil (
      .i_clock    (I_CLOCK),
      .i_srst     (I_SRST),
      .i_awaddr   (I_AXI_AWADDR),
      .i_awvalid  (I_AXI_AWVALID),
      .i_wdata    (I_AXI_WDATA),
      .i_wstrb    (I_AXI_WSTRB),
      .i_wvalid   (I_AXI_WVALID),
      .i_bready   (I_AXI_BREADY),
      .i_araddr   (I_AXI_ARADDR),
      .i_arvalid  (I_AXI_ARVALID),
      .i_rready   (I_AXI_RREADY),
      .o_st       (axs),
      .o_wr_valid (wr_valid),
      .o_wr       (wr),
      .i_wr_ok    (wr_ok),
      .o_rd_valid (rd_valid),
      .o_rd_addr  (rd_addr),
      .i_rd       (rd)
   );

   // word index of each access; the two low address bits are ignored
   assign wr_idx = wr.addr[17:2];
   assign rd_idx = rd_addr[17:2];
   assign bit_pos = wr.data[`WIT_BITOP_POS_HI:0];

   // write decode: unmapped writes answer decerr and change nothing
   always_comb
   begin
      case (wr_idx)
         `WIT_IDX_MODE,
         `WIT_IDX_CLEAR,
         `WIT_IDX_ENABLE,
         `WIT_IDX_BITOP: wr_ok = 1'b1;
         default:        wr_ok = 1'b0;
      endcase
   end

   // read mux; the clear register is write-only and reads zero
   always_comb
   begin
      rd = '{data: 32'h0, ok: 1'b1};
      case (rd_idx)
         `WIT_IDX_MODE:   rd.data = {24'h0, c_r.mode};
         `WIT_IDX_STATUS: rd.data = {30'h0, c_r.status};
         `WIT_IDX_ENABLE: rd.data = {30'h0, c_r.irq_en};
         `WIT_IDX_CLEAR,
         `WIT_IDX_BITOP:  rd.data = 32'h0;
         `WIT_IDX_COUNT:  rd.data = {11'h0, c_r.cnt, 5'h0, c_r.pre};
         default:         rd.ok = 1'b0;
      endcase
   end

   // one watch-clock tick; the divider runs only while enabled so a start
   // always begins a fresh 128-cycle period
   always_comb
   begin
      if (!c_r.mode.operation_enable)
         tick = 1'b0;
      else if (c_r.mode.count_clock_select)
         tick = sub_rise;
      else
         tick = &c_r.div;
   end

   // tap k pulses on the tick that completes 2^k watch-clock cycles
   always_comb
   begin
      hit[0] = tick;
      for (int k = 1; k < 12; k++)
         hit[k] = hit[k-1] & c_r.pre[k-1];
   end

   assign run_watch = c_r.mode.operation_enable & c_r.mode.counter_run;

   // watch period select; the long periods ride on the counter, so the first
   // one after a start may be up to one 2^9 tap early
   always_comb
   begin
      case (c_r.mode.watch_period_select)
         2'b00:   watch_ev = hit[`WIT_TAP_COUNT] & (c_r.cnt == `WIT_CNT_LAST);
         2'b01:   watch_ev = hit[`WIT_TAP_COUNT] & (c_r.cnt[3:0] == `WIT_CNT_HALF);
         2'b10:   watch_ev = hit[`WIT_TAP_W5];
         2'b11:   watch_ev = hit[`WIT_TAP_W4];
         default: watch_ev = 1'b0;
      endcase
   end

   // write-one-to-clear mask for the status bits
   assign clr = (wr_valid && wr_idx == `WIT_IDX_CLEAR && wr.strb[0]) ? wr.data[1:0] : 2'h0;

   // next state of the core
   always_comb
   begin
      c_nxt = c_r;

      // register writes: whole mode byte, one mode bit alone, or the enable bits
      if (wr_valid && wr.strb[0])
      begin
         if (wr_idx == `WIT_IDX_MODE)
            c_nxt.mode = wr.data[7:0];
         if (wr_idx == `WIT_IDX_BITOP)
            c_nxt.mode[bit_pos] = wr.data[`WIT_BITOP_VAL];
         if (wr_idx == `WIT_IDX_ENABLE)
            c_nxt.irq_en = wr.data[1:0];
      end

      // divider and prescaler; a stopped block holds both at zero
      if (!c_r.mode.operation_enable)
      begin
         c_nxt.div = '0;
         c_nxt.pre = '0;
      end
      else
      begin
         c_nxt.div = c_r.div + 7'h1;
         if (tick)
            c_nxt.pre = c_r.pre + 11'h1;
      end

      // the 5-bit counter counts 2^9 taps only while both bits are set
      if (!run_watch)
         c_nxt.cnt = '0;
      else if (hit[`WIT_TAP_COUNT])
         c_nxt.cnt = c_r.cnt + 5'h1;

      // one-cycle interrupt pulses
      c_nxt.intv_p  = hit[`WIT_TAP_IBASE + {1'b0, c_r.mode.interval_select}];
      c_nxt.watch_p = run_watch & watch_ev;

      // sticky status: a new event wins over a clear in the same cycle
      c_nxt.status = c_r.status & ~clr;
      c_nxt.status[`WIT_EV_WATCH] = c_nxt.status[`WIT_EV_WATCH] | c_nxt.watch_p;
      c_nxt.status[`WIT_EV_INTV]  = c_nxt.status[`WIT_EV_INTV] | c_nxt.intv_p;
      c_nxt.irq = |(c_nxt.status & c_nxt.irq_en);
   end

   // core registers; reset leaves the timer stopped with all codes zero
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         c_r        <= '0;
         c_r.mode   <= `WIT_MODE_RESET;
         c_r.irq_en <= `WIT_EN_RESET;
      end
      else
         c_r <= c_nxt;
   end

   // outputs straight from flops
   assign O_AXI_AWREADY  = axs.awrdy;
   assign O_AXI_WREADY   = axs.wrdy;
   assign O_AXI_BRESP    = axs.bresp;
   assign O_AXI_BVALID   = axs.bvalid;
   assign O_AXI_ARREADY  = axs.ardy;
   assign O_AXI_RDATA    = axs.rdata;
   assign O_AXI_RRESP    = axs.rresp;
   assign O_AXI_RVALID   = axs.rvalid;
   assign O_WATCH_IRQ    = c_r.watch_p;
   assign O_INTERVAL_IRQ = c_r.intv_p;
   assign O_IRQ          = c_r.irq;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the watch and interval timer
`timescale 1ns/1ps
`default_nettype none
`include "wit_defs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic        clk, rst, sub, awv, wv, bre, arv, rre;
   logic        awr, wrd, bv, arr, rv, wirq, iirq, irq;
   logic [17:0] awa, ara;
   logic [31:0] wd, rdat, d;
   logic [1:0]  br, rr, r;
   int          n_errors, n_compared, nw, ni, ph, g, i, p, c, k;
   // rows: mode byte, watch (1) or interval (0) output, period in clocks (sub tick 2, fx tick 128)
   logic [7:0]  rm [11] = '{8'h81, 8'h91, 8'ha1, 8'hb1, 8'hc1, 8'hd1, 8'he1, 8'hf1, 8'h01, 8'h8b, 8'h8f};
   bit          rs [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
   int          rp [11] = '{32, 64, 128, 256, 512, 1024, 2048, 4096, 2048, 64, 32};

   wit_top u_dut
   (
      .I_CLOCK(clk), .I_SRST(rst), .I_SUB_CLK(sub),
      .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr),
      .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wv), .O_AXI_WREADY(wrd),
      .O_AXI_BRESP(br), .O_AXI_BVALID(bv), .I_AXI_BREADY(bre),
      .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
      .O_AXI_RDATA(rdat), .O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(rre),
      .O_WATCH_IRQ(wirq), .O_INTERVAL_IRQ(iirq), .O_IRQ(irq)
   );

   initial
   begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end

   // subsystem clock of two system cycles keeps the long periods inside the run; pulses counted by nba
   always @(posedge clk)
   begin
      ph  <= rst ? 0 : ph + 1;
      sub <= ph[0];
      nw  <= rst ? 0 : nw + (wirq === 1'b1);
      ni  <= rst ? 0 : ni + (iirq === 1'b1);
   end

   task results();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one clock with a shared bound on every wait
   task automatic step();
      @(posedge clk);
      g++;
      if (g > 40000)
      begin
         n_errors++;
         results();
      end
   endtask

   task automatic wr(input logic [15:0] x, input logic [31:0] v, output logic [1:0] q);
      bit ta, tw;
      ta = 0;
      tw = 0;
      g = 0;
      awa <= {x, 2'h0};
      wd <= v;
      awv <= 1;
      wv <= 1;
      while (!(ta && tw))
      begin
         step();
         ta |= awr;
         tw |= wrd;
         awv <= !ta;
         wv <= !tw;
      end
      while (!bv) step();
      bre <= 1;
      step();
      q = br;
      bre <= 0;
   endtask

   // ready is raised late so the held answer is exercised
   task automatic rd(input logic [15:0] x, output logic [31:0] v, output logic [1:0] q);
      g = 0;
      ara <= {x, 2'h0};
      arv <= 1;
      do step(); while (!arr);
      arv <= 0;
      while (!rv) step();
      rre <= 1;
      step();
      v = rdat;
      q = rr;
      rre <= 0;
   endtask

   task automatic rc(input string n, input logic [15:0] x, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  q;
      rd(x, v, q);
      `CHK(n, e, v)
   endtask

   // clocks between two pulses of the chosen output
   task automatic meas(input bit s, output int t);
      int n0;
      g = 0;
      n0 = s ? nw : ni;
      while ((s ? nw : ni) == n0) step();
      n0 = s ? nw : ni;
      t = 0;
      while ((s ? nw : ni) == n0)
      begin
         step();
         t++;
      end
   endtask

   initial
   begin
      rst = 1;
      {awv, wv, bre, arv, rre, awa, ara, wd} = '0;
      {n_errors, n_compared} = 0;
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      rc("mode", `WIT_IDX_MODE, 0);
      rc("enable", `WIT_IDX_ENABLE, 0);
      // settings change only while stopped
      for (i = 0; i < 11; i++)
      begin
         wr(`WIT_IDX_MODE, 0, r);
         wr(`WIT_IDX_MODE, rm[i], r);
         meas(rs[i], p);
         `CHK("period", rp[i], p)
      end
      // long watch periods from a cleared prescaler: first pulse at most 2^9 ticks late
      for (i = 0; i < 2; i++)
      begin
         wr(`WIT_IDX_MODE, 0, r);
         wr(`WIT_IDX_MODE, i ? 32'h83 : 32'h87, r);
         k = nw;
         g = 0;
         p = 0;
         while (nw == k)
         begin
            step();
            p++;
         end
         c = i ? 32768 : 16384;
         `CHK("first watch", 1'b1, p > c - 16 && p <= c + 1040)
      end
      wr(`WIT_IDX_MODE, 0, r);
      wr(`WIT_IDX_MODE, 32'h5c, r);
      `CHK("bresp ok", `WIT_RESP_OKAY, r)
      wr(`WIT_IDX_BITOP, 32'h9, r);
      rc("mode", `WIT_IDX_MODE, 32'h5e);
      wr(16'hff75, 32'h1, r);
      `CHK("bresp", `WIT_RESP_DECERR, r)
      rd(16'hff75, d, r);
      `CHK("rresp", `WIT_RESP_DECERR, r)
      // zero-second start: counter one step in, then counter_run dropped alone
      wr(`WIT_IDX_MODE, 0, r);
      wr(`WIT_IDX_MODE, 32'h8f, r);
      repeat (1500) @(posedge clk);
      `CHK("masked irq", 1'b0, irq)
      rd(`WIT_IDX_COUNT, d, r);
      `CHK("counter", 5'h1, d[20:16])
      wr(`WIT_IDX_BITOP, 32'h1, r);
      c = nw;
      k = ni;
      rd(`WIT_IDX_COUNT, d, r);
      `CHK("counter", 5'h0, d[20:16])
      `CHK("prescaler kept", 1'b1, d[10:0] > 11'h200)
      repeat (300) @(posedge clk);
      `CHK("watch stopped", c, nw)
      `CHK("interval runs", 1'b1, ni > k)
      rc("status", `WIT_IDX_STATUS, 32'h3);
      wr(`WIT_IDX_MODE, 32'h80, r);
      rc("count", `WIT_IDX_COUNT, 0);
      wr(`WIT_IDX_ENABLE, 32'h2, r);
      `CHK("irq", 1'b1, irq)
      wr(`WIT_IDX_CLEAR, 32'h2, r);
      `CHK("irq cleared", 1'b0, irq)
      rc("status", `WIT_IDX_STATUS, 32'h1);
      // second reset in mid-run
      wr(`WIT_IDX_MODE, 32'hff, r);
      rst <= 1;
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      rc("mode", `WIT_IDX_MODE, 0);
      results();
   end
endmodule
`default_nettype wire

// *** test/wit_monitor.sv ***
// checker of the watch and interval timer port behaviour
`timescale 1ns/1ps
`default_nettype none
module wit_monitor
(
   input wire logic        I_CLOCK,
   input wire logic        I_SRST,
   input wire logic        I_AXI_AWVALID,
   input wire logic        O_AXI_AWREADY,
   input wire logic        I_AXI_WVALID,
   input wire logic        O_AXI_WREADY,
   input wire logic        O_AXI_BVALID,
   input wire logic [1:0]  O_AXI_BRESP,
   input wire logic        I_AXI_BREADY,
   input wire logic        I_AXI_ARVALID,
   input wire logic        O_AXI_ARREADY,
   input wire logic        O_AXI_RVALID,
   input wire logic [31:0] O_AXI_RDATA,
   input wire logic        I_AXI_RREADY,
   input wire logic        O_WATCH_IRQ,
   input wire logic        O_INTERVAL_IRQ,
   input wire logic        O_IRQ
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);

   // outputs stay quiet on the first edge after reset
   a_reset_quiet: assert property ($fell(I_SRST) |-> !O_AXI_AWREADY && !O_AXI_BVALID && !O_IRQ && !O_WATCH_IRQ)
      else $error("outputs active right after reset");
   // pulses are one cycle; taps cannot repeat within 16 ticks
   a_watch_pulse: assert property (O_WATCH_IRQ |=> !O_WATCH_IRQ [*8])
      else $error("watch pulse too long");
   a_intv_pulse: assert property (O_INTERVAL_IRQ |=> !O_INTERVAL_IRQ [*8])
      else $error("interval pulse too long");
   // bus timing of the register port
   a_write_answer: assert property (I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY |-> ##2 O_AXI_BVALID)
      else $error("write answer late");
   a_b_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
      else $error("write answer dropped");
   a_read_answer: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID && !O_AXI_ARREADY)
      else $error("read answer late");
   a_r_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
      else $error("read data changed");
   a_ar_busy: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
      else $error("read address taken while busy");

   c_watch: cover property (O_WATCH_IRQ);
   c_intv: cover property (O_INTERVAL_IRQ);
   c_irq: cover property ($rose(O_IRQ));
endmodule

bind wit_top wit_monitor u_mon (.*);
`default_nettype wire
